//--- rtl/dsb_pkg.sv
/*
 * Constants, field layouts and carrier types for the diagnostic status and
 * readback bank.
 * Assumes a 32-bit classic Wishbone slave with word-aligned registers.
 */
`default_nettype none

package dsb_pkg;

   // ==========================================================================
   // Register indices; the byte address is four times the index.
   localparam logic [5:0] IDX_GENERAL_STATUS     = 6'h21;
   localparam logic [5:0] IDX_LIMIT_FAIL_FLAGS   = 6'h23;
   localparam logic [5:0] IDX_INPUT0_RESULT      = 6'h24;
   localparam logic [5:0] IDX_INPUT1_RESULT      = 6'h25;
   localparam logic [5:0] IDX_TEMPERATURE_RESULT = 6'h26;
   localparam logic [5:0] IDX_SELF_DIAG_RESULT   = 6'h27;
   localparam logic [5:0] IDX_COMPARATOR_OFFSET  = 6'h28;
   localparam logic [5:0] IDX_SLEW_CONTROL       = 6'h30;
   localparam logic [5:0] IDX_TARGET_CODE        = 6'h31;
   localparam logic [5:0] IDX_OFFSET_OVERRIDE    = 6'h32;

   // ==========================================================================
   // General status field positions and reset value.
   localparam int          GS_RESET_BIT       = 8;
   localparam int          GS_SLEW_DONE_BIT   = 7;
   localparam int          GS_CONV_DONE_BIT   = 6;
   localparam int          GS_CONV_BUSY_BIT   = 5;
   localparam int          GS_HIGH_SUPPLY_BIT = 4;
   localparam int          GS_BRK_FRAME_BIT   = 3;
   localparam int          GS_BRK_PARITY_BIT  = 2;
   localparam int          GS_CHR_FRAME_BIT   = 1;
   localparam int          GS_CHR_PARITY_BIT  = 0;
   localparam logic [15:0] GS_RESET_VALUE     = 16'h0180;

   // ==========================================================================
   // Limit fail flags: bits 8..1 are used, the rest are reserved.
   localparam int          LF_LSB       = 1;
   localparam int          LF_WIDTH     = 8;
   localparam int          RESULT_WIDTH = 12;
   localparam int          CODE_WIDTH   = 16;

   // Control fields of the locally defined registers.
   localparam int          SC_SLEW_EN_BIT   = 0;
   localparam int          OO_ENABLE_BIT    = 15;
   localparam logic [15:0] CTRL_RESET_VALUE = 16'h0000;

   // ==========================================================================
   // Timing: one slew step every SLEW_STEP_NS nanoseconds at 125 MHz.
   localparam int CLK_PERIOD_PS   = 8000;
   localparam int SLEW_STEP_NS    = 128;
   localparam int SLEW_STEP_CYCLES = (SLEW_STEP_NS * 1000) / CLK_PERIOD_PS;

   typedef enum logic [1:0] {
      DSB_CH_INPUT0    = 2'h0,
      DSB_CH_INPUT1    = 2'h1,
      DSB_CH_TEMP      = 2'h3,
      DSB_CH_SELF_DIAG = 2'h2
   } dsb_channel_e;

   // One converter report, valid in the cycle that done is high.
   typedef struct packed {
      logic                    done;
      logic                    busy;
      dsb_channel_e            channel;
      logic [RESULT_WIDTH-1:0] data;
   } dsb_conv_s;

   // One-cycle error pulses from the serial receiver.
   typedef struct packed {
      logic brk_frame;
      logic brk_parity;
      logic chr_frame;
      logic chr_parity;
   } dsb_rx_err_s;

endpackage

`default_nettype wire

//--- rtl/dsb_status_bank.sv
/*
 * Read-only status and readback bank of the diagnostic converter, with the
 * output code slew engine whose progress it reports.
 * Assumes the converter, the serial receiver and the limit checker run on
 * clk_i; only the high supply comparator arrives asynchronously.
 */
`default_nettype none

// Overview of operation
// - Reset-occurred bit reads 1 after reset, clears on status read, no interrupt.
// - Slew-done low while slewing, high when applied equals target, resets to 1.
// - Slewing off: slew-done rises within three cycles of a new target.
// - Slewing on: event pulse when applied code reaches the target.
// - Disabling slewing early jumps the applied code straight to the target.
// - Sticky conversion-done bit per end of conversion, cleared by status read.
// - Live converter-busy bit, high only while converting, no interrupt.
// - Live high-supply bit follows the secondary supply comparator.
// - Sticky break-frame error bit, cleared by status read.
// - Sticky break-parity error bit, cleared by status read.
// - Sticky character-frame error bit, cleared by status read.
// - Sticky character-parity error bit, cleared by status read.
// - Limit fail flags in bits 8 to 1, other bits reserved.
// - Input zero result in bits 11-0, upper bits reserved.
// - Input one result in bits 11-0, upper bits reserved.
// - Temperature result in bits 11-0 of its own register.
// - Self-diagnostic result in bits 11-0 of its own register.
// - Measured comparator offset in bits 11-0 of the offset register.
// - Override enabled: bypass data becomes offset; register still shows measured.
module dsb_status_bank #(
   parameter int SLEW_STEP = dsb_pkg::SLEW_STEP_CYCLES
) (
   input  wire logic                                 clk_i,
   input  wire logic                                 rst_i,
   // Wishbone classic slave.
   input  wire logic                                 wb_cyc_i,
   input  wire logic                                 wb_stb_i,
   input  wire logic                                 wb_we_i,
   input  wire logic [7:0]                           wb_adr_i,
   input  wire logic [3:0]                           wb_sel_i,
   input  wire logic [31:0]                          wb_dat_i,
   output logic      [31:0]                          wb_dat_o,
   output logic                                      wb_ack_o,
   // Converter, receiver and limit checker.
   input  wire dsb_pkg::dsb_conv_s                   conv_i,
   input  wire dsb_pkg::dsb_rx_err_s                 rx_err_i,
   input  wire logic [dsb_pkg::LF_WIDTH-1:0]         limit_fail_i,
   input  wire logic [dsb_pkg::RESULT_WIDTH-1:0]     meas_offset_i,
   input  wire logic                                 high_supply_i,
   // Outputs to the analog side.
   output logic      [dsb_pkg::CODE_WIDTH-1:0]       applied_code_o,
   output logic      [dsb_pkg::RESULT_WIDTH-1:0]     conv_offset_o,
   output logic                                      slew_reached_o
);

   // ==========================================================================
   // Bus decode
   logic        req;
   logic        rd_ack;
   logic        wr_ack;
   logic        status_read;
   logic [5:0]  idx;
   logic        ack_ff;
   logic [31:0] rdata_ff;

   assign req         = wb_cyc_i & wb_stb_i & ~ack_ff;
   assign idx         = wb_adr_i[7:2];
   assign rd_ack      = req & ~wb_we_i;
   assign wr_ack      = req & wb_we_i;
   assign status_read = rd_ack & (idx == dsb_pkg::IDX_GENERAL_STATUS);
   assign wb_ack_o    = ack_ff;
   assign wb_dat_o    = rdata_ff;

   function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] wd,
                                            input logic [3:0]  sel);
      merge16 = {sel[1] ? wd[15:8] : old_v[15:8], sel[0] ? wd[7:0] : old_v[7:0]};
   endfunction

   function automatic logic [31:0] zext12(input logic [dsb_pkg::RESULT_WIDTH-1:0] v);
      zext12 = {20'h00000, v};
   endfunction

   // ==========================================================================
   // Locally defined control registers
   logic [15:0] slew_ctrl_ff;
   logic [15:0] target_ff;
   logic [15:0] override_ff;
   logic        slew_en;
   logic        target_wr;

   assign slew_en   = slew_ctrl_ff[dsb_pkg::SC_SLEW_EN_BIT];
   assign target_wr = wr_ack & (idx == dsb_pkg::IDX_TARGET_CODE);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         slew_ctrl_ff <= dsb_pkg::CTRL_RESET_VALUE;
         target_ff    <= dsb_pkg::CTRL_RESET_VALUE;
         override_ff  <= dsb_pkg::CTRL_RESET_VALUE;
      end else if (wr_ack) begin
         case (idx)
            dsb_pkg::IDX_SLEW_CONTROL: begin
               slew_ctrl_ff <= merge16(slew_ctrl_ff, wb_dat_i, wb_sel_i) & 16'h0001;
            end
            dsb_pkg::IDX_TARGET_CODE: begin
               target_ff <= merge16(target_ff, wb_dat_i, wb_sel_i);
            end
            dsb_pkg::IDX_OFFSET_OVERRIDE: begin
               override_ff <= merge16(override_ff, wb_dat_i, wb_sel_i) & 16'h8fff;
            end
            default: begin
               // Read-only and unmapped words drop the write.
               slew_ctrl_ff <= slew_ctrl_ff;
            end
         endcase
      end
   end

   // ==========================================================================
   // Slew engine
   // The step timer restarts on every target write so a fresh ramp always
   // starts with a full step interval.
   logic [15:0] applied_ff;
   logic [15:0] step_cnt_ff;
   logic        step_tick;
   logic        slew_done_ff;
   logic        slew_reached_ff;
   logic        nxt_done;
   logic [15:0] nxt_applied;

   assign step_tick = (step_cnt_ff == 16'(SLEW_STEP - 1));

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         step_cnt_ff <= 16'h0000;
      end else if (target_wr | step_tick | ~slew_en) begin
         step_cnt_ff <= 16'h0000;
      end else begin
         step_cnt_ff <= step_cnt_ff + 16'h0001;
      end
   end

   always_comb begin
      nxt_applied = applied_ff;
      if (!slew_en) begin
         nxt_applied = target_ff;
      end else if (step_tick && applied_ff < target_ff) begin
         nxt_applied = applied_ff + 16'h0001;
      end else if (step_tick && applied_ff > target_ff) begin
         nxt_applied = applied_ff - 16'h0001;
      end
   end

   assign nxt_done = (nxt_applied == target_ff);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         applied_ff      <= 16'h0000;
         slew_done_ff    <= 1'b1;
         slew_reached_ff <= 1'b0;
      end else begin
         applied_ff      <= nxt_applied;
         slew_done_ff    <= nxt_done & ~target_wr;
         slew_reached_ff <= slew_en & nxt_done & ~target_wr & ~slew_done_ff;
      end
   end

   assign applied_code_o = applied_ff;
   assign slew_reached_o = slew_reached_ff;

   // ==========================================================================
   // General status
   // A status read clears the sticky bits, but an event in the same cycle
   // sets them again so it is never lost.
   logic [1:0] supply_sync_ff;
   logic       reset_seen_ff;
   logic       conv_done_ff;
   logic       conv_busy_ff;
   logic [3:0] rx_err_ff;
   logic [3:0] rx_set;

   assign rx_set = {rx_err_i.brk_frame, rx_err_i.brk_parity,
                    rx_err_i.chr_frame, rx_err_i.chr_parity};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         supply_sync_ff <= 2'h0;
      end else begin
         supply_sync_ff <= {supply_sync_ff[0], high_supply_i};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reset_seen_ff <= 1'b1;
         conv_done_ff  <= 1'b0;
         conv_busy_ff  <= 1'b0;
         rx_err_ff     <= 4'h0;
      end else begin
         reset_seen_ff <= reset_seen_ff & ~status_read;
         conv_done_ff  <= (conv_done_ff & ~status_read) | conv_i.done;
         conv_busy_ff  <= conv_i.busy;
         rx_err_ff     <= (rx_err_ff & {4{~status_read}}) | rx_set;
      end
   end

   logic [15:0] status_word;

   always_comb begin
      status_word                                = 16'h0000;
      status_word[dsb_pkg::GS_RESET_BIT]         = reset_seen_ff;
      status_word[dsb_pkg::GS_SLEW_DONE_BIT]     = slew_done_ff;
      status_word[dsb_pkg::GS_CONV_DONE_BIT]     = conv_done_ff;
      status_word[dsb_pkg::GS_CONV_BUSY_BIT]     = conv_busy_ff;
      status_word[dsb_pkg::GS_HIGH_SUPPLY_BIT]   = supply_sync_ff[1];
      status_word[dsb_pkg::GS_BRK_FRAME_BIT]     = rx_err_ff[3];
      status_word[dsb_pkg::GS_BRK_PARITY_BIT]    = rx_err_ff[2];
      status_word[dsb_pkg::GS_CHR_FRAME_BIT]     = rx_err_ff[1];
      status_word[dsb_pkg::GS_CHR_PARITY_BIT]    = rx_err_ff[0];
   end

   // ==========================================================================
   // Results, flags and offset
   logic [dsb_pkg::RESULT_WIDTH-1:0] result_ff [4];
   logic [dsb_pkg::LF_WIDTH-1:0]     limit_ff;
   logic [dsb_pkg::RESULT_WIDTH-1:0] offset_ff;

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_result
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               result_ff[g] <= '0;
            end else if (conv_i.done && conv_i.channel == dsb_pkg::dsb_channel_e'(g)) begin
               result_ff[g] <= conv_i.data;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         limit_ff  <= '0;
         offset_ff <= '0;
      end else begin
         limit_ff  <= limit_fail_i;
         offset_ff <= meas_offset_i;
      end
   end

   // The converter takes the override only as its working offset; software
   // keeps seeing the measured figure.
   assign conv_offset_o = override_ff[dsb_pkg::OO_ENABLE_BIT] ?
                          override_ff[dsb_pkg::RESULT_WIDTH-1:0] : offset_ff;

   // ==========================================================================
   // Read mux and acknowledge
   // Every access is acknowledged one cycle after the strobe; unmapped words
   // read as zero instead of erroring so software probing stays harmless.
   logic [31:0] nxt_rdata;

   always_comb begin
      case (idx)
         dsb_pkg::IDX_GENERAL_STATUS: begin
            nxt_rdata = {16'h0000, status_word};
         end
         dsb_pkg::IDX_LIMIT_FAIL_FLAGS: begin
            nxt_rdata = {23'h0, limit_ff, 1'b0};
         end
         dsb_pkg::IDX_INPUT0_RESULT: begin
            nxt_rdata = zext12(result_ff[dsb_pkg::DSB_CH_INPUT0]);
         end
         dsb_pkg::IDX_INPUT1_RESULT: begin
            nxt_rdata = zext12(result_ff[dsb_pkg::DSB_CH_INPUT1]);
         end
         dsb_pkg::IDX_TEMPERATURE_RESULT: begin
            nxt_rdata = zext12(result_ff[dsb_pkg::DSB_CH_TEMP]);
         end
         dsb_pkg::IDX_SELF_DIAG_RESULT: begin
            nxt_rdata = zext12(result_ff[dsb_pkg::DSB_CH_SELF_DIAG]);
         end
         dsb_pkg::IDX_COMPARATOR_OFFSET: begin
            nxt_rdata = zext12(offset_ff);
         end
         dsb_pkg::IDX_SLEW_CONTROL: begin
            nxt_rdata = {16'h0000, slew_ctrl_ff};
         end
         dsb_pkg::IDX_TARGET_CODE: begin
            nxt_rdata = {16'h0000, target_ff};
         end
         dsb_pkg::IDX_OFFSET_OVERRIDE: begin
            nxt_rdata = {16'h0000, override_ff};
         end
         default: begin
            nxt_rdata = 32'h00000000;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff   <= 1'b0;
         rdata_ff <= 32'h00000000;
      end else begin
         ack_ff   <= req;
         rdata_ff <= rd_ack ? nxt_rdata : 32'h00000000;
      end
   end

   // ==========================================================================
   // Assertions
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   property p_reset_clear;
      status_read |=> !reset_seen_ff;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("reset bit not cleared");

   property p_slew_busy;
      (applied_ff != target_ff) |-> !slew_done_ff;
   endproperty
   a_slew_busy: assert property (p_slew_busy) else $error("slew done while slewing");

   property p_fast_done;
      (target_wr && !slew_en) |-> ##[1:3] slew_done_ff;
   endproperty
   a_fast_done: assert property (p_fast_done) else $error("slew done late");

   property p_reach_event;
      ($rose(slew_done_ff) && $past(slew_en)) |-> slew_reached_o;
   endproperty
   a_reach_event: assert property (p_reach_event) else $error("no reach event");

   property p_jump;
      !slew_en |=> (applied_ff == $past(target_ff));
   endproperty
   a_jump: assert property (p_jump) else $error("applied code did not jump");

   property p_conv_done;
      conv_i.done |=> conv_done_ff ##0 status_word[dsb_pkg::GS_CONV_DONE_BIT];
   endproperty
   a_conv_done: assert property (p_conv_done) else $error("conversion done lost");

   property p_busy;
      conv_i.busy ##1 !conv_i.busy |-> conv_busy_ff ##1 !conv_busy_ff;
   endproperty
   a_busy: assert property (p_busy) else $error("busy bit wrong");

   property p_supply;
      high_supply_i [*3] |-> status_word[dsb_pkg::GS_HIGH_SUPPLY_BIT];
   endproperty
   a_supply: assert property (p_supply) else $error("high supply bit wrong");

   property p_rx_sticky;
      (rx_set != 4'h0) |=> ((rx_err_ff & $past(rx_set)) == $past(rx_set));
   endproperty
   a_rx_sticky: assert property (p_rx_sticky) else $error("receive error lost");

   property p_input0;
      (conv_i.done && conv_i.channel == dsb_pkg::DSB_CH_INPUT0)
         |=> (result_ff[0] == $past(conv_i.data));
   endproperty
   a_input0: assert property (p_input0) else $error("input zero result not stored");

   property p_offset;
      !override_ff[dsb_pkg::OO_ENABLE_BIT] |-> (conv_offset_o == offset_ff);
   endproperty
   a_offset: assert property (p_offset) else $error("offset mux wrong");

   property p_reserved;
      (rd_ack && idx >= dsb_pkg::IDX_INPUT0_RESULT && idx <= dsb_pkg::IDX_COMPARATOR_OFFSET)
         |=> (wb_ack_o && wb_dat_o[31:12] == 20'h00000);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

endmodule

`default_nettype wire

//--- tb/diag_status_readback_bank_tb.sv
/*
 * Self-checking bench for the diagnostic status and readback bank.
 * Assumes the design package is compiled first and one 125 MHz clock.
 */
`default_nettype none

module diag_status_readback_bank_tb;
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================================
   // Stimulus signals and the device under test.
   logic                    clk_i;
   logic                    rst_i;
   logic                    wb_cyc;
   logic                    wb_stb;
   logic                    wb_we;
   logic [7:0]              wb_adr;
   logic [3:0]              wb_sel;
   logic [31:0]             wb_wdat;
   logic [31:0]             wb_dat_o;
   logic                    wb_ack_o;
   dsb_pkg::dsb_conv_s      conv;
   dsb_pkg::dsb_rx_err_s    rx_err;
   logic [7:0]              limit_fail;
   logic [11:0]             meas_offset;
   logic                    high_supply;
   logic [15:0]             applied_code_o;
   logic [11:0]             conv_offset_o;
   logic                    slew_reached_o;
   int                      n_fail = 0;
   int                      n_tests = 0;

   // A short slew step keeps the slewing scenarios brief.
   dsb_status_bank #(.SLEW_STEP(2)) dsb_status_bank_i (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .conv_i(conv), .rx_err_i(rx_err),
      .limit_fail_i(limit_fail), .meas_offset_i(meas_offset),
      .high_supply_i(high_supply), .applied_code_o(applied_code_o),
      .conv_offset_o(conv_offset_o), .slew_reached_o(slew_reached_o));

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   // ==========================================================================
   // Shared tasks.
   function automatic logic [7:0] ad(input logic [5:0] idx);
      return {idx, 2'b00};
   endfunction

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // One classic cycle; entered just after a rising edge, returns one idle cycle later.
   task automatic wb(input logic we, input logic [7:0] adr, input logic [15:0] wd,
                     output logic [31:0] rd);
      int n;
      wb_cyc  <= 1'b1;
      wb_stb  <= 1'b1;
      wb_we   <= we;
      wb_adr  <= adr;
      wb_sel  <= 4'h3;
      wb_wdat <= {16'h0000, wd};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we  <= 1'b0;
      // The slave answers in the cycle after it takes the request.
      chk("ack latency", 32'(n), 32'h2);
      @(posedge clk_i);
      chk("ack drop", {31'h0, wb_ack_o}, 32'h0);
   endtask

   task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp, input string nm);
      logic [31:0] rd;
      wb(1'b0, adr, 16'h0000, rd);
      chk(nm, rd, exp);
   endtask

   task automatic wr(input logic [7:0] adr, input logic [15:0] wd);
      logic [31:0] rd;
      wb(1'b1, adr, wd, rd);
   endtask

   task automatic status_bit(input int b, input logic exp, input string nm);
      logic [31:0] rd;
      wb(1'b0, ad(dsb_pkg::IDX_GENERAL_STATUS), 16'h0000, rd);
      chk(nm, {31'h0, rd[b]}, {31'h0, exp});
   endtask

   // ==========================================================================
   // Scenarios.
   task automatic t_reset();
      rdchk(ad(dsb_pkg::IDX_GENERAL_STATUS), 32'h0180, "status after reset");
      rdchk(ad(dsb_pkg::IDX_GENERAL_STATUS), 32'h0080, "status reread");
      for (int i = 3; i <= 8; i++) begin
         rdchk(ad(6'h20 + 6'(i)), 32'h0, "result reset");
      end
      $display("test reset done");
   endtask

   task automatic t_sticky();
      dsb_pkg::dsb_channel_e chs[4];
      logic [5:0]            idx[4];
      chs = '{dsb_pkg::DSB_CH_INPUT0, dsb_pkg::DSB_CH_INPUT1,
              dsb_pkg::DSB_CH_TEMP, dsb_pkg::DSB_CH_SELF_DIAG};
      idx = '{dsb_pkg::IDX_INPUT0_RESULT, dsb_pkg::IDX_INPUT1_RESULT,
              dsb_pkg::IDX_TEMPERATURE_RESULT, dsb_pkg::IDX_SELF_DIAG_RESULT};
      for (int b = 0; b < 4; b++) begin
         rx_err <= dsb_pkg::dsb_rx_err_s'(4'h1 << b);
         @(posedge clk_i);
         rx_err <= '0;
         @(posedge clk_i);
         rdchk(ad(dsb_pkg::IDX_GENERAL_STATUS), 32'h0080 | (32'h1 << b), "rx err set");
         rdchk(ad(dsb_pkg::IDX_GENERAL_STATUS), 32'h0080, "rx err cleared");
      end
      // Each channel gets a distinct value so a swapped register shows.
      for (int i = 0; i < 4; i++) begin
         conv.done    <= 1'b1;
         conv.channel <= chs[i];
         conv.data    <= 12'hf30 + 12'(i * 17);
         @(posedge clk_i);
         conv.done <= 1'b0;
         @(posedge clk_i);
      end
      for (int i = 0; i < 4; i++) begin
         rdchk(ad(idx[i]), 32'(12'hf30 + 12'(i * 17)), "result load");
      end
      wr(ad(dsb_pkg::IDX_INPUT0_RESULT), 16'hffff);
      rdchk(ad(dsb_pkg::IDX_INPUT0_RESULT), 32'h0f30, "read-only write");
      rdchk(8'hfc, 32'h0, "unmapped read");
      rdchk(ad(dsb_pkg::IDX_GENERAL_STATUS), 32'h00c0, "conv done set");
      rdchk(ad(dsb_pkg::IDX_GENERAL_STATUS), 32'h0080, "conv done cleared");
      $display("test sticky done");
   endtask

   task automatic t_live();
      conv.busy   <= 1'b1;
      high_supply <= 1'b1;
      limit_fail  <= 8'ha5;
      meas_offset <= 12'habc;
      repeat (3) @(posedge clk_i);
      rdchk(ad(dsb_pkg::IDX_GENERAL_STATUS), 32'h00b0, "live bits high");
      rdchk(ad(dsb_pkg::IDX_LIMIT_FAIL_FLAGS), 32'h014a, "limit flags");
      rdchk(ad(dsb_pkg::IDX_COMPARATOR_OFFSET), 32'h0abc, "offset");
      chk("conv offset", 32'(conv_offset_o), 32'h0abc);
      wr(ad(dsb_pkg::IDX_OFFSET_OVERRIDE), 16'h8123);
      @(posedge clk_i);
      chk("override offset", 32'(conv_offset_o), 32'h0123);
      rdchk(ad(dsb_pkg::IDX_COMPARATOR_OFFSET), 32'h0abc, "offset under override");
      wr(ad(dsb_pkg::IDX_OFFSET_OVERRIDE), 16'h0123);
      conv.busy   <= 1'b0;
      high_supply <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk("override off", 32'(conv_offset_o), 32'h0abc);
      rdchk(ad(dsb_pkg::IDX_GENERAL_STATUS), 32'h0080, "live bits low");
      $display("test live done");
   endtask

   task automatic t_slew();
      int n;
      wr(ad(dsb_pkg::IDX_TARGET_CODE), 16'h1234);
      repeat (2) @(posedge clk_i);
      chk("jump without slew", 32'(applied_code_o), 32'h1234);
      status_bit(7, 1'b1, "slew done no slew");
      wr(ad(dsb_pkg::IDX_SLEW_CONTROL), 16'h0001);
      wr(ad(dsb_pkg::IDX_TARGET_CODE), 16'h1264);
      status_bit(7, 1'b0, "slew done while slewing");
      chk("no jump while slewing", {31'h0, applied_code_o === 16'h1264}, 32'h0);
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (slew_reached_o !== 1'b1 && n < 300);
      chk("reached pulse", {31'h0, slew_reached_o}, 32'h1);
      @(posedge clk_i);
      chk("applied at target", 32'(applied_code_o), 32'h1264);
      chk("reached one cycle", {31'h0, slew_reached_o}, 32'h0);
      status_bit(7, 1'b1, "slew done at target");
      wr(ad(dsb_pkg::IDX_TARGET_CODE), 16'h0000);
      wr(ad(dsb_pkg::IDX_SLEW_CONTROL), 16'h0000);
      repeat (3) @(posedge clk_i);
      chk("jump on disable", 32'(applied_code_o), 32'h0000);
      $display("test slew done");
   endtask

   // ==========================================================================
   // Run control.
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      rst_i = 1'b1; wb_cyc = 1'b0; wb_stb = 1'b0; wb_we = 1'b0;
      wb_adr = 8'h00; wb_sel = 4'h0; wb_wdat = 32'h0;
      conv = '0; rx_err = '0; limit_fail = 8'h00; meas_offset = 12'h000;
      high_supply = 1'b0;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_sticky();
      t_live();
      t_slew();
      end_sim();
   end

   // The scenarios need a few hundred cycles; this limit leaves wide margin.
   initial begin
      #200000;
      n_fail++;
      end_sim();
   end

endmodule

`default_nettype wire
